// >>> hdl/ebi_regs.svh
// Constants of the external bus interface
`ifndef EBI_REGS_SVH
`define EBI_REGS_SVH
`define EBI_AW        20
`define EBI_DW        16
`define EBI_CW        4
`define EBI_Z0_AW     12
`define EBI_Z0_HI     8'h00
`define EBI_ZN        3
`define EBI_WB_DEPTH  2'h3
`define EBI_WB_LAST   2'h2
`define EBI_LEAD_RST  3'h6
`define EBI_ACT_RST   3'h7
`define EBI_TRL_RST   2'h3
`define EBI_CS_OFF    3'h7
`define EBI_CNT_ONE   4'h1
`define EBI_PER_SLOW  2'h3
`define EBI_PER_FAST  2'h1
`endif

// >>> hdl/ebi_pkg.sv
// Types shared by the external bus interface modules
package ebi_pkg;
`include "ebi_regs.svh"
  typedef enum logic [1:0] {
    EBI_Z0 = 2'b00,
    EBI_Z6 = 2'b01,
    EBI_Z7 = 2'b10
  } ebi_zone_t;
  typedef struct packed {
    logic [2:0] lead;
    logic [2:0] active;
    logic [1:0] trail;
  } ebi_phase_t;
  typedef struct packed {
    ebi_phase_t rd;
    ebi_phase_t wr;
    logic       dbl;
    logic       rdy_en;
  } ebi_zcfg_t;
  typedef struct packed {
    logic                wr;
    ebi_zone_t           zone;
    logic [`EBI_AW-1:0]  addr;
    logic [`EBI_DW-1:0]  data;
  } ebi_acc_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LEAD   = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_TRAIL  = 2'b11
  } ebi_state_t;
  localparam ebi_phase_t EBI_PH_RST = '{
    lead: `EBI_LEAD_RST, active: `EBI_ACT_RST, trail: `EBI_TRL_RST};
  localparam ebi_zcfg_t EBI_ZCFG_RST = '{
    rd: EBI_PH_RST, wr: EBI_PH_RST, dbl: 1'b0, rdy_en: 1'b0};
endpackage : ebi_pkg

// >>> hdl/ebi_if.sv
// Interfaces between the bus engine, clock divider and write buffer
`timescale 1ns/1ps
interface ebi_clk_if;
  logic timing_half;
  logic out_half;
  logic clk_off;
  logic tick;
  logic rise;
  logic outclk;
  logic outclk_oe;
  modport gen (input timing_half, out_half, clk_off,
               output tick, rise, outclk, outclk_oe);
  modport eng (output timing_half, out_half, clk_off,
               input tick, rise, outclk, outclk_oe);
endinterface : ebi_clk_if

interface ebi_q_if;
  import ebi_pkg::*;
  logic       push;
  logic       pop;
  logic       valid;
  ebi_acc_t   wdata;
  ebi_acc_t   head;
  logic [1:0] count;
  modport fifo (input push, pop, wdata, output valid, head, count);
  modport eng (output push, pop, wdata, input valid, head, count);
endinterface : ebi_q_if

// >>> hdl/ebi_clkgen.sv
// Timing clock steps and output bus clock divider
`timescale 1ns/1ps
module ebi_clkgen (
  input wire logic clk,
  input wire logic rst,
  ebi_clk_if.gen   ck
);
  import ebi_pkg::*;

  logic [1:0] ph_ff;
  logic [1:0] plen;
  logic [1:0] nxt_ph;
  logic       tick_ff;
  logic       rise_ff;
  logic       outclk_ff;
  logic       oe_ff;

  // ----------------------------------------
  // Divider phase
  // ----------------------------------------
  always_comb begin
    plen = (ck.timing_half && ck.out_half) ? `EBI_PER_SLOW : `EBI_PER_FAST;
    nxt_ph = (ph_ff >= plen) ? 2'h0 : ph_ff + 2'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_ff     <= 2'h0;
      tick_ff   <= 1'b0;
      rise_ff   <= 1'b0;
      outclk_ff <= 1'b0;
      oe_ff     <= 1'b1;
    end else begin
      ph_ff     <= nxt_ph;
      tick_ff   <= ck.timing_half ? nxt_ph[0] : 1'b1;
      rise_ff   <= (nxt_ph == plen);
      outclk_ff <= (nxt_ph <= (plen >> 1));
      oe_ff     <= ~ck.clk_off;
    end
  end

  assign ck.tick      = tick_ff;
  assign ck.rise      = rise_ff;
  assign ck.outclk    = outclk_ff;
  assign ck.outclk_oe = oe_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_tick_half_rate:
    assert property (ck.tick && ck.timing_half && $past(ck.timing_half)
                     |=> !ck.tick)
    else $error("timing step not at half rate");
  a_tick_full_rate:
    assert property (!ck.timing_half |=> ck.tick)
    else $error("timing step missing at full rate");
  a_out_quarter:
    assert property (disable iff (rst || !(ck.timing_half && ck.out_half))
                     ck.rise |=> !ck.rise [*3] ##1 ck.rise)
    else $error("output clock not a quarter of system clock");
  a_clk_off_pin:
    assert property (ck.clk_off |=> !ck.outclk_oe)
    else $error("output clock driven while disabled");
endmodule : ebi_clkgen

// >>> hdl/ebi_wbuf.sv
// Access queue holding every accepted read and write in order
`timescale 1ns/1ps
module ebi_wbuf (
  input wire logic clk,
  input wire logic rst,
  ebi_q_if.fifo    q
);
  import ebi_pkg::*;

  ebi_acc_t   mem [`EBI_ZN];
  logic [1:0] wp_ff;
  logic [1:0] rp_ff;
  logic [1:0] cnt_ff;
  logic       push_ok;
  logic       pop_ok;

  function automatic logic [1:0] ebi_inc(input logic [1:0] p);
    return (p == `EBI_WB_LAST) ? 2'h0 : p + 2'h1;
  endfunction : ebi_inc

  assign push_ok = q.push && (cnt_ff != `EBI_WB_DEPTH);
  assign pop_ok  = q.pop && (cnt_ff != 2'h0);

  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem[wp_ff] <= q.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_ff  <= 2'h0;
      rp_ff  <= 2'h0;
      cnt_ff <= 2'h0;
    end else begin
      if (push_ok) begin
        wp_ff <= ebi_inc(wp_ff);
      end
      if (pop_ok) begin
        rp_ff <= ebi_inc(rp_ff);
      end
      unique case ({push_ok, pop_ok})
        2'b10: cnt_ff <= cnt_ff + 2'h1;
        2'b01: cnt_ff <= cnt_ff - 2'h1;
        default: cnt_ff <= cnt_ff;
      endcase
    end
  end

  assign q.valid = (cnt_ff != 2'h0);
  assign q.head  = mem[rp_ff];
  assign q.count = cnt_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fifo_no_over:
    assert property (q.push |-> cnt_ff != `EBI_WB_DEPTH)
    else $error("write pushed into a full queue");
endmodule : ebi_wbuf

// >>> hdl/ebi_top.sv
// External asynchronous bus interface: zones, timing, write buffer
//
// How it works
// - Zone 0 accesses run in program order; writes finish before reads.
// - A read after a write waits idle until that write has finished.
// - Timing clock runs at system clock or half; half after reset.
// - Every bus access begins on an output bus clock rising edge.
// - Output clock is a quarter of system clock when both half bits are set, else half; quarter after reset.
// - Setting the clock disable bit stops driving the output clock pin.
// - Write buffer off after reset; up to three writes taken unstalled.
// - Access has lead, active and trail phases counted in timing steps.
// - Each zone has separate read and write phase counts.
// - Zone doubling bit doubles its lead, active and trail counts.
// - Lead phase drives zone chip select low and the address out.
// - Lead defaults to six timing steps for every zone and direction.
// - Zone 0 drives addresses 0 to 0xfff; zones 6, 7 full range.
// - One shared 20-bit address bus; chip select alone names the zone.
// - Zone may extend active phase until external ready goes high.
`timescale 1ns/1ps
`include "ebi_regs.svh"
module ebi_top (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire ebi_pkg::ebi_zone_t     req_zone,
  input  wire logic [`EBI_AW-1:0]     req_addr,
  input  wire logic [`EBI_DW-1:0]     req_wdata,
  output logic                        req_ready,
  output logic                        rd_valid,
  output logic [`EBI_DW-1:0]          rd_data,
  input  wire logic                   cfg_load,
  input  wire logic                   cfg_timing_half,
  input  wire logic                   cfg_out_half,
  input  wire logic                   cfg_clk_off,
  input  wire logic [1:0]             cfg_wbuf_depth,
  input  wire ebi_pkg::ebi_zcfg_t [2:0] cfg_zone,
  output logic                        bus_idle,
  output logic                        bus_output_clock,
  output logic                        bus_output_clock_oe,
  output logic                        zone0_chip_select_n,
  output logic                        zone6_chip_select_n,
  output logic                        zone7_chip_select_n,
  output logic [`EBI_AW-1:0]          external_address_bus,
  output logic                        read_strobe_n,
  output logic                        write_strobe_n,
  input  wire logic [`EBI_DW-1:0]     data_in,
  output logic [`EBI_DW-1:0]          data_out,
  output logic                        data_oe,
  input  wire logic                   external_ready_input
);
  import ebi_pkg::*;

  ebi_clk_if ck ();
  ebi_q_if   q ();

  logic                tim_half_ff;
  logic                out_half_ff;
  logic                clk_off_ff;
  logic [1:0]          depth_ff;
  ebi_zcfg_t [2:0]     zcfg_ff;
  ebi_state_t          state_ff;
  logic [`EBI_CW-1:0]  cnt_ff;
  ebi_acc_t            acc_ff;
  logic                hold_ff;
  logic                ready_ff;
  logic                idle_ff;
  logic [2:0]          cs_n_ff;
  logic [`EBI_AW-1:0]  addr_ff;
  logic                rd_n_ff;
  logic                wr_n_ff;
  logic [`EBI_DW-1:0]  dout_ff;
  logic                doe_ff;
  logic [`EBI_DW-1:0]  rdata_ff;
  logic                rvalid_ff;
  logic                rdy_s1_ff;
  logic                rdy_s2_ff;
  logic [`EBI_DW-1:0]  din_s1_ff;
  logic [`EBI_DW-1:0]  din_s2_ff;
  logic [`EBI_CW-1:0]  lt_ff;
  logic [`EBI_CW-1:0]  exp_ff;
  ebi_zcfg_t           hd_cfg;
  ebi_zcfg_t           cur_cfg;
  ebi_phase_t          hd_ph;
  ebi_phase_t          cur_ph;
  logic                busy;
  logic [2:0]          occ;
  logic                take;
  logic                buf_ok;
  logic                start;
  logic                lead_end;
  logic                act_end;
  logic                done;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic ebi_zcfg_t ebi_zsel(input ebi_zcfg_t [2:0] c,
                                         input ebi_zone_t z);
    unique case (z)
      EBI_Z0:  return c[0];
      EBI_Z6:  return c[1];
      EBI_Z7:  return c[2];
      default: return c[2];
    endcase
  endfunction : ebi_zsel

  function automatic ebi_phase_t ebi_dir(input ebi_zcfg_t c,
                                         input logic wr);
    return wr ? c.wr : c.rd;
  endfunction : ebi_dir

  function automatic logic [`EBI_CW-1:0] ebi_len(input logic [2:0] n,
                                                 input logic dbl);
    logic [2:0] m;
    m = (n == 3'h0) ? 3'h1 : n;
    return dbl ? {m, 1'b0} : {1'b0, m};
  endfunction : ebi_len

  // ----------------------------------------
  // Configuration word
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tim_half_ff <= 1'b1;
      out_half_ff <= 1'b1;
      clk_off_ff  <= 1'b0;
      depth_ff    <= 2'h0;
      for (int i = 0; i < `EBI_ZN; i++) begin
        zcfg_ff[i] <= EBI_ZCFG_RST;
      end
    end else if (cfg_load) begin
      // Requester keeps the bus quiet across a load
      tim_half_ff <= cfg_timing_half;
      out_half_ff <= cfg_out_half;
      clk_off_ff  <= cfg_clk_off;
      depth_ff    <= (cfg_wbuf_depth > `EBI_WB_DEPTH) ? `EBI_WB_DEPTH
                                                      : cfg_wbuf_depth;
      for (int i = 0; i < `EBI_ZN; i++) begin
        zcfg_ff[i] <= cfg_zone[i];
      end
    end
  end

  assign ck.timing_half = tim_half_ff;
  assign ck.out_half    = out_half_ff;
  assign ck.clk_off     = clk_off_ff;

  ebi_clkgen u_clkgen (.clk(clk), .rst(rst), .ck(ck.gen));
  ebi_wbuf   u_wbuf   (.clk(clk), .rst(rst), .q(q.fifo));

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy_s1_ff <= 1'b0;
      rdy_s2_ff <= 1'b0;
      din_s1_ff <= '0;
      din_s2_ff <= '0;
    end else begin
      rdy_s1_ff <= external_ready_input;
      rdy_s2_ff <= rdy_s1_ff;
      din_s1_ff <= data_in;
      din_s2_ff <= din_s1_ff;
    end
  end

  // ----------------------------------------
  // Request intake
  // ----------------------------------------
  assign busy    = (state_ff != ST_IDLE);
  assign occ     = {1'b0, q.count} + {2'b00, busy};
  assign take    = req_valid && ready_ff;
  assign buf_ok  = req_write && (depth_ff != 2'h0);
  assign q.push  = take;
  assign q.wdata = '{wr: req_write, zone: req_zone, addr: req_addr,
                     data: req_wdata};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_ff  <= 1'b0;
      ready_ff <= 1'b0;
      idle_ff  <= 1'b1;
    end else begin
      if (take && !buf_ok) begin
        hold_ff <= 1'b1;
      end else if (done && (q.count == 2'h0)) begin
        hold_ff <= 1'b0;
      end
      // Reads and unbuffered writes wait for an empty bus
      ready_ff <= !take && !hold_ff &&
                  (buf_ok ? (occ < {1'b0, depth_ff})
                          : (occ == 3'h0));
      idle_ff  <= (occ == 3'h0) && !take;
    end
  end

  // ----------------------------------------
  // Access engine
  // ----------------------------------------
  assign hd_cfg   = ebi_zsel(zcfg_ff, q.head.zone);
  assign hd_ph    = ebi_dir(hd_cfg, q.head.wr);
  assign cur_cfg  = ebi_zsel(zcfg_ff, acc_ff.zone);
  assign cur_ph   = ebi_dir(cur_cfg, acc_ff.wr);
  assign start    = !busy && q.valid && ck.rise;
  assign q.pop    = start;
  assign lead_end = (state_ff == ST_LEAD) && ck.tick &&
                    (cnt_ff == `EBI_CNT_ONE);
  assign act_end  = (state_ff == ST_ACTIVE) && ck.tick &&
                    (cnt_ff == `EBI_CNT_ONE) &&
                    (!cur_cfg.rdy_en || rdy_s2_ff);
  assign done     = (state_ff == ST_TRAIL) && ck.tick &&
                    (cnt_ff == `EBI_CNT_ONE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      acc_ff   <= '0;
    end else begin
      unique case (state_ff)
        ST_IDLE: if (start) begin
          state_ff <= ST_LEAD;
          cnt_ff   <= ebi_len(hd_ph.lead, hd_cfg.dbl);
          acc_ff   <= q.head;
        end
        ST_LEAD: if (lead_end) begin
          state_ff <= ST_ACTIVE;
          cnt_ff   <= ebi_len(cur_ph.active, cur_cfg.dbl);
        end else if (ck.tick) begin
          cnt_ff <= cnt_ff - `EBI_CNT_ONE;
        end
        ST_ACTIVE: if (act_end) begin
          state_ff <= ST_TRAIL;
          cnt_ff   <= ebi_len({1'b0, cur_ph.trail}, cur_cfg.dbl);
        end else if (ck.tick && (cnt_ff != `EBI_CNT_ONE)) begin
          cnt_ff <= cnt_ff - `EBI_CNT_ONE;
        end
        ST_TRAIL: if (done) begin
          state_ff <= ST_IDLE;
        end else if (ck.tick) begin
          cnt_ff <= cnt_ff - `EBI_CNT_ONE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Bus pins
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_n_ff   <= `EBI_CS_OFF;
      addr_ff   <= '0;
      rd_n_ff   <= 1'b1;
      wr_n_ff   <= 1'b1;
      dout_ff   <= '0;
      doe_ff    <= 1'b0;
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= done && !acc_ff.wr;
      if (start) begin
        cs_n_ff <= ~(3'b001 << q.head.zone);
        addr_ff <= (q.head.zone == EBI_Z0)
                   ? {`EBI_Z0_HI, q.head.addr[`EBI_Z0_AW-1:0]}
                   : q.head.addr;
        dout_ff <= q.head.data;
        doe_ff  <= q.head.wr;
      end else if (done) begin
        cs_n_ff <= `EBI_CS_OFF;
        doe_ff  <= 1'b0;
      end
      if (lead_end) begin
        rd_n_ff <= acc_ff.wr;
        wr_n_ff <= !acc_ff.wr;
      end else if (act_end) begin
        rd_n_ff  <= 1'b1;
        wr_n_ff  <= 1'b1;
        rdata_ff <= acc_ff.wr ? rdata_ff : din_s2_ff;
      end
    end
  end

  assign req_ready            = ready_ff;
  assign rd_valid             = rvalid_ff;
  assign rd_data              = rdata_ff;
  assign bus_idle             = idle_ff;
  assign bus_output_clock     = ck.outclk;
  assign bus_output_clock_oe  = ck.outclk_oe;
  assign zone0_chip_select_n  = cs_n_ff[0];
  assign zone6_chip_select_n  = cs_n_ff[1];
  assign zone7_chip_select_n  = cs_n_ff[2];
  assign external_address_bus = addr_ff;
  assign read_strobe_n        = rd_n_ff;
  assign write_strobe_n       = wr_n_ff;
  assign data_out             = dout_ff;
  assign data_oe              = doe_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lt_ff  <= '0;
      exp_ff <= '0;
    end else if (start) begin
      lt_ff  <= '0;
      exp_ff <= ebi_len(hd_ph.lead, hd_cfg.dbl);
    end else if ((state_ff == ST_LEAD) && ck.tick) begin
      lt_ff <= lt_ff + `EBI_CNT_ONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_on_rise:
    assert property (state_ff == ST_IDLE ##1 state_ff == ST_LEAD
                     |-> $past(ck.rise) && $rose(ck.outclk))
    else $error("access started off an output clock edge");
  a_cs_in_lead:
    assert property (state_ff == ST_LEAD
                     |-> cs_n_ff != `EBI_CS_OFF && rd_n_ff && wr_n_ff)
    else $error("lead phase without chip select or with strobe");
  a_strobe_active:
    assert property (!rd_n_ff || !wr_n_ff |-> state_ff == ST_ACTIVE)
    else $error("strobe outside active phase");
  a_cs_release:
    assert property (state_ff == ST_TRAIL ##1 state_ff == ST_IDLE
                     |-> cs_n_ff == `EBI_CS_OFF && !doe_ff)
    else $error("chip select held after trail");
  a_zone0_addr:
    assert property (!cs_n_ff[0]
                     |-> addr_ff[`EBI_AW-1:`EBI_Z0_AW] == `EBI_Z0_HI)
    else $error("zone 0 address out of range");
  a_read_alone:
    assert property (start && !q.head.wr |-> q.count == 2'h1)
    else $error("read issued ahead of queued writes");
  a_lead_ticks:
    assert property (lead_end |-> lt_ff == exp_ff - `EBI_CNT_ONE)
    else $error("lead phase length wrong");
  a_ready_extend:
    assert property (state_ff == ST_ACTIVE ##1 state_ff == ST_TRAIL
                     |-> !$past(cur_cfg.rdy_en) || $past(rdy_s2_ff))
    else $error("active phase ended without external ready");
  a_lead_reset:
    assert property ($fell(rst) |-> zcfg_ff[0].rd.lead == `EBI_LEAD_RST
                     && zcfg_ff[2].wr.lead == `EBI_LEAD_RST)
    else $error("lead not at six after reset");
  a_wbuf_reset:
    assert property ($fell(rst) |-> depth_ff == 2'h0 && !hold_ff)
    else $error("write buffer enabled after reset");

  c_read_done:
    cover property (rd_valid);
  c_buf_full:
    cover property (occ == 3'h3 && depth_ff == `EBI_WB_DEPTH);
  c_ready_stall:
    cover property (state_ff == ST_ACTIVE && ck.tick && cur_cfg.rdy_en
                    && cnt_ff == `EBI_CNT_ONE && !rdy_s2_ff);
endmodule : ebi_top

// >>> tb/ebi_mem_model.sv
// External asynchronous memory with ready stretch
`timescale 1ns/1ps
module ebi_mem_model (
  input  wire logic        clk,
  input  wire logic        cs_n,
  input  wire logic [19:0] addr,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] din,
  input  wire logic [3:0]  slow,
  output logic [15:0]      dout,
  output logic             rdy
);
  logic [15:0] mem [0:15];
  logic [3:0]  wcnt;
  logic        stb;
  assign stb = !cs_n && !(rd_n && wr_n);
  initial begin
    dout = 16'h0;
    rdy  = 1'b1;
    wcnt = 4'h0;
    for (int i = 0; i < 16; i++) mem[i] = 16'h1000 + 16'(i);
  end
  // Store on write strobe, drive on read strobe, else toggle
  always @(posedge clk) begin
    if (!cs_n && !wr_n) mem[addr[3:0]] <= din;
    if (!cs_n && !rd_n) dout <= mem[addr[3:0]];
    else dout <= ~dout;
  end
  // Ready held low for slow cycles of each strobe
  always @(posedge clk) begin
    wcnt <= stb ? wcnt + 4'(wcnt != 4'hf) : 4'h0;
    rdy  <= !(stb && wcnt < slow);
  end
endmodule : ebi_mem_model

// >>> tb/testbench.sv
// Self-checking bench for the external bus interface
`timescale 1ns/1ps
`include "ebi_regs.svh"
module testbench;
  import ebi_pkg::*;
  logic clk, rst, req_valid, req_write, req_ready, rd_valid, cfg_load;
  logic cfg_timing_half, cfg_out_half, cfg_clk_off, bus_idle, oclk, oclk_oe;
  logic cs0_n, cs6_n, cs7_n, rd_n, wr_n, data_oe, rdy;
  logic [1:0]  cfg_wbuf_depth;
  logic [3:0]  slow;
  logic [19:0] req_addr, xaddr;
  logic [15:0] req_wdata, rd_data, data_in, data_out;
  ebi_zone_t   req_zone;
  ebi_zcfg_t [2:0] zc;
  int err_total, n_compared, l, a, t, p;
  logic ck, oe;
  logic [2:0] csv;
  realtime t0;
  wire cs_all = cs0_n & cs6_n & cs7_n;
  wire stb_n  = rd_n & wr_n;
  ebi_top ebi_top_inst (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_zone(req_zone), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .cfg_load(cfg_load), .cfg_timing_half(cfg_timing_half),
    .cfg_out_half(cfg_out_half), .cfg_clk_off(cfg_clk_off),
    .cfg_wbuf_depth(cfg_wbuf_depth), .cfg_zone(zc), .bus_idle(bus_idle),
    .bus_output_clock(oclk), .bus_output_clock_oe(oclk_oe),
    .zone0_chip_select_n(cs0_n), .zone6_chip_select_n(cs6_n),
    .zone7_chip_select_n(cs7_n), .external_address_bus(xaddr),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .external_ready_input(rdy));
  ebi_mem_model ebi_mem_model_inst (.clk(clk), .cs_n(cs_all), .addr(xaddr),
    .rd_n(rd_n), .wr_n(wr_n), .din(data_out), .slow(slow), .dout(data_in),
    .rdy(rdy));
  always #5 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic req(input logic w, ebi_zone_t z, logic [19:0] ad,
                     logic [15:0] d);
    req_valid = 1'b1; req_write = w; req_zone = z; req_addr = ad;
    req_wdata = d;
    do @(posedge clk); while (req_ready !== 1'b1);
    #1 req_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask : req
  task automatic rd(input ebi_zone_t z, logic [19:0] ad);
    req(1'b0, z, ad, 16'h0);
    while (rd_valid !== 1'b1) begin @(posedge clk); #1; end
  endtask : rd
  task automatic measure();
    while (cs_all) begin @(posedge clk); #1; end
    ck = oclk; csv = {cs7_n, cs6_n, cs0_n}; oe = data_oe;
    l = 0; a = 0; t = 0;
    while (stb_n) begin @(posedge clk); #1; l++; end
    while (!stb_n) begin @(posedge clk); #1; a++; end
    while (!cs_all) begin @(posedge clk); #1; t++; end
  endtask : measure
  task automatic cfg(input logic th, oh, off, input logic [1:0] dep);
    while (bus_idle !== 1'b1) begin @(posedge clk); #1; end
    cfg_timing_half = th; cfg_out_half = oh; cfg_clk_off = off;
    cfg_wbuf_depth = dep; cfg_load = 1'b1;
    @(posedge clk);
    #1 cfg_load = 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask : cfg
  task automatic period();
    @(posedge oclk); t0 = $realtime; @(posedge oclk);
    p = int'(($realtime - t0) / 10.0);
    #1;
  endtask : period
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    period(); chk("outclk period", 4, p);
    chk("outclk oe", 1, oclk_oe);
    fork rd(EBI_Z6, 20'habcd5); measure(); join
    chk("lead", 12, l);
    chk("active", 14, a);
    chk("trail", 6, t);
    chk("clk at start", 1, ck);
    chk("cs vector", 3'b101, csv);
    chk("rd oe", 0, oe);
    chk("rd data", 16'h1005, rd_data);
    fork rd(EBI_Z0, 20'h12fff); measure(); join
    chk("z0 addr", 20'h00fff, xaddr);
    chk("z0 cs", 3'b110, csv);
  endtask : t_defaults
  task automatic t_timing();
    zc[2] = '{rd: '{3'h2, 3'h4, 2'h1}, wr: '{3'h3, 3'h5, 2'h2},
              dbl: 1'b0, rdy_en: 1'b0};
    cfg(1'b0, 1'b0, 1'b0, 2'h0);
    period(); chk("fast period", 2, p);
    fork rd(EBI_Z7, 20'h00003); measure(); join
    chk("rd phases", {8'd2, 8'd4, 8'd1}, {8'(l), 8'(a), 8'(t)});
    chk("fast clk start", 1, ck);
    chk("z7 cs", 3'b011, csv);
    fork req(1'b1, EBI_Z7, 20'h00004, 16'h0); measure(); join
    chk("wr phases", {8'd3, 8'd5, 8'd2}, {8'(l), 8'(a), 8'(t)});
    chk("wr oe", 1, oe);
    repeat (3) @(posedge clk);
    #1;
    zc[2].dbl = 1'b1;
    cfg(1'b0, 1'b0, 1'b0, 2'h0);
    fork rd(EBI_Z7, 20'h00003); measure(); join
    chk("dbl phases", {8'd4, 8'd8, 8'd2}, {8'(l), 8'(a), 8'(t)});
  endtask : t_timing
  task automatic t_order();
    cfg(1'b0, 1'b0, 1'b0, 2'h3);
    t0 = $realtime;
    for (int i = 1; i < 4; i++) req(1'b1, EBI_Z0, 20'(i), 16'ha0 + 16'(i));
    chk("three unstalled", 1, ($realtime - t0) < 160.0);
    rd(EBI_Z0, 20'h00003);
    chk("rd after wr", 16'ha3, rd_data);
    rd(EBI_Z0, 20'h00001);
    chk("wr in order", 16'ha1, rd_data);
  endtask : t_order
  task automatic t_ready();
    zc[2] = '{rd: '{3'h2, 3'h4, 2'h1}, wr: '{3'h3, 3'h5, 2'h2},
              dbl: 1'b0, rdy_en: 1'b1};
    slow = 4'h8;
    cfg(1'b0, 1'b0, 1'b0, 2'h0);
    fork rd(EBI_Z7, 20'h00002); measure(); join
    chk("ready stretch", 1, a > 4);
    cfg(1'b0, 1'b0, 1'b1, 2'h0);
    chk("outclk off", 0, oclk_oe);
  endtask : t_ready
  initial begin
    clk = 0; rst = 1; req_valid = 0; req_write = 0; req_zone = EBI_Z0;
    req_addr = 0; req_wdata = 0; cfg_load = 0; cfg_timing_half = 1;
    cfg_out_half = 1; cfg_clk_off = 0; cfg_wbuf_depth = 0; slow = 0;
    err_total = 0; n_compared = 0;
    zc = {3{EBI_ZCFG_RST}};
    repeat (10) @(posedge clk);
    #1 rst = 0;
    repeat (2) @(posedge clk);
    #1;
    t_defaults();
    t_timing();
    t_order();
    t_ready();
    results();
  end
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule : testbench
